// [common/addr_step_if.sv]
`timescale 1ns/10ps
interface addr_step_if;
  import dma_chan_pkg::*;
  logic load;
  logic [ADDR_W-1:0] loadValue;
  logic step;
  logic incr;
  logic byteUnit;
  logic wrap;
  logic [ADDR_W-1:0] addr;
  modport ctrl (output load, loadValue, step, incr, byteUnit, wrap, input addr);
  modport stepper (input load, loadValue, step, incr, byteUnit, wrap, output addr);
endinterface

// [common/dma_chan_pkg.sv]
package dma_chan_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int REG_AW = 4;
  localparam int CTRL_W = 8;
  localparam int IRQ_W = 2;
  localparam int RING_W = 5;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [REG_AW-1:0] OFF_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] OFF_SWREQ = 4'h2;
  localparam logic [REG_AW-1:0] OFF_SRC = 4'h4;
  localparam logic [REG_AW-1:0] OFF_DST = 4'h6;
  localparam logic [REG_AW-1:0] OFF_IRQ_STAT = 4'h8;
  localparam logic [REG_AW-1:0] OFF_IRQ_MASK = 4'hA;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int BIT_RING = 0;
  localparam int BIT_REQ = 1;
  localparam int BIT_CAUSE_LO = 2;
  localparam int BIT_CAUSE_HI = 3;
  localparam int BIT_EN = 4;
  localparam int BIT_SIZE = 5;
  localparam int BIT_SRC_INC = 6;
  localparam int BIT_DST_INC = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // Interrupt status and mask layout
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DROP = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------
  // Ring buffer and address stepping
  // ----------------------------------------
  localparam logic [RING_W-1:0] RING_FIRST = 5'h00;
  localparam logic [RING_W-1:0] RING_LAST = 5'h1F;
  localparam logic [RING_W-1:0] RING_ONE = 5'h01;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_HALF = 16'h0002;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    CAUSE_SW = 2'b00,
    CAUSE_SERIAL = 2'b01,
    CAUSE_TIMER = 2'b10,
    CAUSE_CHAIN = 2'b11
  } cause_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } state_e;

  function automatic logic [ADDR_W-1:0] stepOf(input logic byteUnit);
    stepOf = byteUnit ? STEP_BYTE : STEP_HALF;
  endfunction

endpackage

// [test/dma_mover_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Transfer mover on the far side
// ----------------------------------------
// Answers each raised request once, after ackDelay idle cycles, so the
// bench can make it prompt (0) or slow enough to change the enable mid-unit.
module dma_mover_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic xferReq,
  input wire logic [3:0] ackDelay,
  output logic xferAck
);
  logic [3:0] waitCnt;

  initial begin
    xferAck = 1'b0;
    waitCnt = 4'h0;
  end

  always @(posedge sys_clk) begin
    if (rst || !xferReq || xferAck) begin
      xferAck <= 1'b0;
      waitCnt <= 4'h0;
    end else if (waitCnt >= ackDelay) begin
      xferAck <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// [test/tb.sv]
`timescale 1ns/10ps
module tb;
  import dma_chan_pkg::*;
  logic sys_clk, rst, regWrite, regRead, txBufEmpty, timerInPin, prevUnitDone;
  logic xferReq, xferAck, xferByteUnit, unitDone, irq, rdPend;
  logic [REG_AW-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, rdE;
  logic [ADDR_W-1:0] xferSrcAddr, xferDstAddr, srcE, dstE;
  logic [3:0] ackDelay;
  logic [2*ADDR_W:0] unitE;
  logic [DATA_W-1:0] rdQ[$];
  logic [2*ADDR_W:0] unitQ[$];
  int err_total, check_count;

  dma_channel_control dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .txBufEmpty(txBufEmpty), .timerInPin(timerInPin), .prevUnitDone(prevUnitDone),
    .xferReq(xferReq), .xferAck(xferAck), .xferSrcAddr(xferSrcAddr),
    .xferDstAddr(xferDstAddr), .xferByteUnit(xferByteUnit), .unitDone(unitDone), .irq(irq));
  dma_mover_model mover (.sys_clk(sys_clk), .rst(rst), .xferReq(xferReq),
    .ackDelay(ackDelay), .xferAck(xferAck));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                       input string msg);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Bus and request tasks
  // ----------------------------------------
  // A gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] exp);
    rdQ.push_back(exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic setCtl(input logic ring, input logic [1:0] cause, input logic en,
                        input logic bu, input logic si, input logic di);
    wr(OFF_CTRL, {8'h00, di, si, bu, en, cause, 1'b1, ring});
  endtask

  task automatic load(input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] d);
    srcE = s;
    dstE = d;
    wr(OFF_SRC, s);
    wr(OFF_DST, d);
  endtask

  task automatic expUnit(input logic bu, input logic si, input logic di);
    if (si) srcE = srcE + (bu ? 16'h0001 : 16'h0002);
    if (di) dstE = dstE + (bu ? 16'h0001 : 16'h0002);
    unitQ.push_back({srcE, dstE, bu});
  endtask

  // Waits until every noted unit is done; the tail catches stray units
  task automatic settle();
    int n;
    n = 0;
    while ((unitQ.size() != 0 || xferReq !== 1'b0) && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 300) begin
      err_total++;
      $display("mismatch at %0t: wait for unit timed out", $time);
      stop_test();
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic pulse(input int c);
    if (c == 1) txBufEmpty <= 1'b1;
    else if (c == 2) timerInPin <= 1'b1;
    else prevUnitDone <= 1'b1;
    @(posedge sys_clk);
    prevUnitDone <= 1'b0;
    repeat (6) @(posedge sys_clk);
    txBufEmpty <= 1'b0;
    timerInPin <= 1'b0;
  endtask

  task automatic chkIrq(input logic exp);
    // Level was launched one edge earlier, so it is settled here
    check({15'h0000, irq}, {15'h0000, exp}, "irq level");
  endtask

  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rdPend) begin
      rdE = (rdQ.size() > 0) ? rdQ.pop_front() : 'x;
      check(regRdData, rdE, "read data");
    end
    rdPend <= regRead;
    if (unitDone === 1'b1) begin
      unitE = (unitQ.size() > 0) ? unitQ.pop_front() : 'x;
      check(xferSrcAddr, unitE[2*ADDR_W:ADDR_W+1], "source address");
      check(xferDstAddr, unitE[ADDR_W:1], "destination address");
      check({15'h0000, xferByteUnit}, {15'h0000, unitE[0]}, "unit size");
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    $display("mismatch at %0t: run limit reached", $time);
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic bu, si, di;
    logic [ADDR_W-1:0] rs, rdst;
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    txBufEmpty = 1'b0;
    timerInPin = 1'b0;
    prevUnitDone = 1'b0;
    ackDelay = 4'h0;
    rdPend = 1'b0;
    void'($urandom(32'hBCA77633));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(OFF_CTRL, 16'h0000);
    rd(OFF_IRQ_STAT, 16'h0000);
    rd(OFF_IRQ_MASK, 16'h0000);
    rd(4'hE, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      bu = i[0];
      si = i[1];
      di = i[0] ^ i[1];
      ackDelay <= 4'($urandom_range(0, 3));
      load(16'($urandom) & 16'hFFFE, 16'($urandom) & 16'hFFFE);
      setCtl(1'b0, CAUSE_SW, 1'b1, bu, si, di);
      expUnit(bu, si, di);
      wr(OFF_SWREQ, 16'($urandom));
      settle();
      rd(OFF_CTRL, {8'h00, di, si, bu, 5'b10000});
    end
    rd(OFF_SRC, srcE);
    rd(OFF_DST, dstE);
    wr(OFF_IRQ_MASK, 16'h0001);
    chkIrq(1'b1);
    rd(OFF_IRQ_STAT, 16'h0001);
    wr(OFF_IRQ_STAT, 16'h0001);
    chkIrq(1'b0);
    // Slow mover so the enable is cleared while the unit is outstanding
    ackDelay <= 4'hC;
    setCtl(1'b0, CAUSE_SW, 1'b1, 1'b0, 1'b1, 1'b0);
    expUnit(1'b0, 1'b1, 1'b0);
    wr(OFF_SWREQ, 16'h0001);
    @(posedge sys_clk);
    setCtl(1'b0, CAUSE_SW, 1'b0, 1'b0, 1'b1, 1'b0);
    // Unit still outstanding: this request must be dropped and reported
    wr(OFF_SWREQ, 16'h0003);
    rd(OFF_IRQ_STAT, 16'h0002);
    wr(OFF_IRQ_STAT, 16'h0002);
    settle();
    wr(OFF_SWREQ, 16'h00A5);
    settle();
    rd(OFF_CTRL, 16'h0042);
    wr(OFF_CTRL, 16'h0042);
    rd(OFF_CTRL, 16'h0042);
    wr(OFF_SWREQ, 16'h5A00);
    rd(OFF_IRQ_STAT, 16'h0003);
    wr(OFF_IRQ_STAT, 16'h0003);
    wr(OFF_CTRL, 16'h0040);
    rd(OFF_CTRL, 16'h0040);
    setCtl(1'b0, CAUSE_SW, 1'b1, 1'b0, 1'b1, 1'b0);
    settle();
    ackDelay <= 4'h1;
    for (int c = 1; c < 4; c++) begin
      setCtl(1'b0, 2'(c), 1'b1, 1'b0, 1'b1, 1'b1);
      wr(OFF_SWREQ, 16'h1234);
      settle();
      expUnit(1'b0, 1'b1, 1'b1);
      pulse(c);
      settle();
    end
    rs = 16'($urandom);
    rdst = 16'($urandom);
    load(rs, rdst);
    wr(OFF_IRQ_STAT, 16'h0003);
    setCtl(1'b1, CAUSE_SW, 1'b1, 1'b1, 1'b1, 1'b1);
    for (int k = 1; k <= 34; k++) begin
      srcE = rs + 16'(k % 32);
      dstE = rdst + 16'(k % 32);
      unitQ.push_back({srcE, dstE, 1'b1});
      wr(OFF_SWREQ, 16'($urandom));
      settle();
    end
    chkIrq(1'b0);
    rd(OFF_IRQ_STAT, 16'h0000);
    settle();
    check(16'(unitQ.size() + rdQ.size()), 16'h0000, "notes left over");
    stop_test();
  end
endmodule

// [verilog/address_stepper.sv]
`timescale 1ns/10ps
module address_stepper
  import dma_chan_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  addr_step_if.stepper step
);

  logic [ADDR_W-1:0] start_r;
  logic [ADDR_W-1:0] start_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;

  // ----------------------------------------
  // Current and start address
  // ----------------------------------------
  always_comb begin
    start_nxt = start_r;
    addr_nxt = addr_r;
    if (step.load) begin
      start_nxt = step.loadValue;
      addr_nxt = step.loadValue;
    end else if (step.step && step.wrap) begin
      addr_nxt = start_r;
    end else if (step.step && step.incr) begin
      addr_nxt = addr_r + stepOf(step.byteUnit);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_r <= ADDR_RESET;
      addr_r <= ADDR_RESET;
    end else begin
      start_r <= start_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign step.addr = addr_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_step_incr;
    @(posedge sys_clk) disable iff (rst)
    step.step && step.incr && !step.wrap && !step.load |=>
      addr_r == $past(addr_r) + (step.byteUnit ? STEP_BYTE : STEP_HALF);
  endproperty
  a_step_incr: assert property (p_step_incr) else $error("address step wrong");

  property p_step_fixed;
    @(posedge sys_clk) disable iff (rst)
    step.step && !step.incr && !step.wrap && !step.load |=> $stable(addr_r);
  endproperty
  a_step_fixed: assert property (p_step_fixed) else $error("fixed address moved");

  property p_step_wrap;
    @(posedge sys_clk) disable iff (rst)
    step.step && step.wrap && !step.load |=> addr_r == start_r;
  endproperty
  a_step_wrap: assert property (p_step_wrap) else $error("ring wrap missed start");

endmodule

// [verilog/dma_channel_control.sv]
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - Control bit 0 picks normal mode at 0 and ring-buffer mode at 1.
// - In ring mode, after 32 transfers the addresses return to their start and repeat.
// - In ring mode the transfer counter free-runs and transfers go on until disabled.
// - In ring mode the completion interrupt is never raised.
// - The request flag in bit 1 is set by each accepted request and is readable.
// - Writing 0 to the request flag clears it; writing 1 leaves it unchanged.
// - A request arriving while the flag is set is refused until the transfer completes, or, before the transfer starts, until a write of 0 clears the flag.
// - Bits 3:2 pick the cause: software, serial buffer empty, timer pin, prior channel.
// - Bit 4 enables transfers at 1 and disables them at 0.
// - Clearing the enable while a transfer is under way still finishes that transfer; an accepted request that has not started waits for the enable.
// - Bit 5 picks 16-bit units at 0 and 8-bit units at 1.
// - Bit 6 keeps the source address fixed at 0 and increments it at 1.
// - Bit 7 keeps the destination address fixed at 0 and increments it at 1.
// - With the software cause, any write to the software-request register is a request.
// - Increments are one per 8-bit unit and two per 16-bit unit; fixed stays put.
module dma_channel_control
  import dma_chan_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  input wire logic txBufEmpty,
  input wire logic timerInPin,
  input wire logic prevUnitDone,
  output logic xferReq,
  input wire logic xferAck,
  output logic [ADDR_W-1:0] xferSrcAddr,
  output logic [ADDR_W-1:0] xferDstAddr,
  output logic xferByteUnit,
  output logic unitDone,
  output logic irq
);

  addr_step_if srcStep ();
  addr_step_if dstStep ();

  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic reqFlag_r;
  logic reqFlag_nxt;
  state_e state_r;
  state_e state_nxt;
  logic byteUnit_r;
  logic byteUnit_nxt;
  logic unitDone_r;
  logic unitDone_nxt;
  logic [RING_W-1:0] ringCnt_r;
  logic [RING_W-1:0] ringCnt_nxt;
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqStat_nxt;
  logic [IRQ_W-1:0] irqMask_r;
  logic [IRQ_W-1:0] irqMask_nxt;
  logic [DATA_W-1:0] rdData_r;
  logic [DATA_W-1:0] rdData_nxt;
  logic [2:0] timerSync_r;
  logic [2:0] timerSync_nxt;
  logic timerLvl_r;
  logic timerLvl_nxt;
  logic txPrev_r;

  logic ringMode;
  logic chanEnable;
  cause_e cause;
  logic ctrlWrite;
  logic reqClear;
  logic swWrite;
  logic timerRise;
  logic serialRise;
  logic reqEvent;
  logic accept;
  logic drop;
  logic go;
  logic doneNow;
  logic ringWrap;

  assign ringMode = ctrl_r[BIT_RING];
  assign chanEnable = ctrl_r[BIT_EN];
  assign cause = cause_e'(ctrl_r[BIT_CAUSE_HI:BIT_CAUSE_LO]);
  assign ctrlWrite = regWrite && (regAddr == OFF_CTRL);
  assign reqClear = ctrlWrite && !regWrData[BIT_REQ];

  // ----------------------------------------
  // Request sources
  // ----------------------------------------
  // Pin goes through three flops; an edge counts once the last two agree
  always_comb begin
    timerSync_nxt = {timerSync_r[1:0], timerInPin};
    timerLvl_nxt = timerLvl_r;
    if (timerSync_r[1] == timerSync_r[2]) begin
      timerLvl_nxt = timerSync_r[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timerSync_r <= 3'h0;
      timerLvl_r <= 1'b0;
      txPrev_r <= 1'b0;
    end else begin
      timerSync_r <= timerSync_nxt;
      timerLvl_r <= timerLvl_nxt;
      txPrev_r <= txBufEmpty;
    end
  end

  assign timerRise = timerLvl_nxt && !timerLvl_r;
  assign serialRise = txBufEmpty && !txPrev_r;
  assign swWrite = regWrite && (regAddr == OFF_SWREQ);

  always_comb begin
    case (cause)
      CAUSE_SW: reqEvent = swWrite;
      CAUSE_SERIAL: reqEvent = serialRise;
      CAUSE_TIMER: reqEvent = timerRise;
      CAUSE_CHAIN: reqEvent = prevUnitDone;
      default: reqEvent = 1'b0;
    endcase
  end

  // Clearing in the same cycle frees the flag, so the new event still lands
  assign accept = reqEvent && (state_r == ST_IDLE) && (!reqFlag_r || reqClear);
  assign drop = reqEvent && !accept;

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  assign go = (state_r == ST_IDLE) && chanEnable && reqFlag_r && !reqClear;
  assign doneNow = (state_r == ST_BUSY) && xferAck;
  assign ringWrap = ringMode && (ringCnt_r == RING_LAST);

  always_comb begin
    state_nxt = state_r;
    byteUnit_nxt = byteUnit_r;
    unitDone_nxt = 1'b0;
    ringCnt_nxt = ringCnt_r;
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_BUSY;
          byteUnit_nxt = ctrl_r[BIT_SIZE];
        end
      end
      ST_BUSY: begin
        // Enable is not looked at here: an accepted unit always completes
        if (xferAck) begin
          state_nxt = ST_IDLE;
          unitDone_nxt = 1'b1;
          if (ringMode) begin
            ringCnt_nxt = ringWrap ? RING_FIRST : RING_W'(ringCnt_r + RING_ONE);
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      byteUnit_r <= 1'b0;
      unitDone_r <= 1'b0;
      ringCnt_r <= RING_FIRST;
    end else begin
      state_r <= state_nxt;
      byteUnit_r <= byteUnit_nxt;
      unitDone_r <= unitDone_nxt;
      ringCnt_r <= ringCnt_nxt;
    end
  end

  assign xferReq = (state_r == ST_BUSY);
  assign xferByteUnit = byteUnit_r;
  assign unitDone = unitDone_r;

  // ----------------------------------------
  // Address steppers
  // ----------------------------------------
  assign srcStep.load = regWrite && (regAddr == OFF_SRC);
  assign srcStep.loadValue = regWrData;
  assign srcStep.step = doneNow;
  assign srcStep.incr = ctrl_r[BIT_SRC_INC];
  assign srcStep.byteUnit = byteUnit_r;
  assign srcStep.wrap = ringWrap;
  assign dstStep.load = regWrite && (regAddr == OFF_DST);
  assign dstStep.loadValue = regWrData;
  assign dstStep.step = doneNow;
  assign dstStep.incr = ctrl_r[BIT_DST_INC];
  assign dstStep.byteUnit = byteUnit_r;
  assign dstStep.wrap = ringWrap;

  address_stepper srcStepper (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(srcStep.stepper)
  );

  address_stepper dstStepper (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(dstStep.stepper)
  );

  assign xferSrcAddr = srcStep.addr;
  assign xferDstAddr = dstStep.addr;

  // ----------------------------------------
  // Registers and interrupt
  // ----------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    reqFlag_nxt = reqFlag_r;
    irqMask_nxt = irqMask_r;
    if (ctrlWrite) begin
      ctrl_nxt = regWrData[CTRL_W-1:0];
      ctrl_nxt[BIT_REQ] = 1'b0;
    end
    if (reqClear || doneNow) begin
      reqFlag_nxt = 1'b0;
    end
    if (accept) begin
      reqFlag_nxt = 1'b1;
    end
    if (regWrite && (regAddr == OFF_IRQ_MASK)) begin
      irqMask_nxt = regWrData[IRQ_W-1:0];
    end
    irqStat_nxt = irqStat_r;
    if (regWrite && (regAddr == OFF_IRQ_STAT)) begin
      irqStat_nxt = irqStat_r & ~regWrData[IRQ_W-1:0];
    end
    // Set after clear so an event in the clearing cycle survives
    if (doneNow && !ringMode) begin
      irqStat_nxt[IRQ_DONE] = 1'b1;
    end
    if (drop) begin
      irqStat_nxt[IRQ_DROP] = 1'b1;
    end
    rdData_nxt = RD_ZERO;
    if (regRead) begin
      case (regAddr)
        OFF_CTRL: rdData_nxt = DATA_W'({ctrl_r[CTRL_W-1:BIT_REQ+1], reqFlag_r, ctrl_r[BIT_RING]});
        OFF_SRC: rdData_nxt = srcStep.addr;
        OFF_DST: rdData_nxt = dstStep.addr;
        OFF_IRQ_STAT: rdData_nxt = DATA_W'(irqStat_r);
        OFF_IRQ_MASK: rdData_nxt = DATA_W'(irqMask_r);
        default: rdData_nxt = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
      reqFlag_r <= 1'b0;
      irqStat_r <= IRQ_RESET;
      irqMask_r <= IRQ_RESET;
      rdData_r <= RD_ZERO;
    end else begin
      ctrl_r <= ctrl_nxt;
      reqFlag_r <= reqFlag_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign irq = |(irqStat_r & irqMask_r);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_mode_done_irq;
    doneNow && !ringMode |=> irqStat_r[IRQ_DONE];
  endproperty
  a_mode_done_irq: assert property (p_mode_done_irq) else $error("normal done lost");
  property p_ring_wrap;
    doneNow && ringMode && ringCnt_r == RING_LAST |=> ringCnt_r == RING_FIRST;
  endproperty
  a_ring_wrap: assert property (p_ring_wrap) else $error("ring count did not wrap");
  property p_ring_count;
    doneNow && ringMode && ringCnt_r != RING_LAST |=> ringCnt_r == $past(ringCnt_r) + RING_ONE;
  endproperty
  a_ring_count: assert property (p_ring_count) else $error("ring count stuck");
  property p_ring_no_irq;
    doneNow && ringMode && !irqStat_r[IRQ_DONE] |=> !irqStat_r[IRQ_DONE];
  endproperty
  a_ring_no_irq: assert property (p_ring_no_irq) else $error("ring raised done");
  property p_flag_set;
    accept |=> reqFlag_r ##1 (reqFlag_r || $past(reqClear) || $past(doneNow));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("request flag not set");
  property p_flag_write_one;
    ctrlWrite && regWrData[BIT_REQ] && !accept && !doneNow |=> $stable(reqFlag_r);
  endproperty
  a_flag_write_one: assert property (p_flag_write_one) else $error("write one changed flag");
  // A request while busy must be refused and show up as a drop
  property p_busy_refuse;
    state_r == ST_BUSY && reqEvent |-> !accept ##1 irqStat_r[IRQ_DROP];
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("request taken while busy");
  property p_cause_sw;
    swWrite && cause != CAUSE_SW && !serialRise && !timerRise && !prevUnitDone |-> !reqEvent;
  endproperty
  a_cause_sw: assert property (p_cause_sw) else $error("wrong cause selected");
  property p_disabled_idle;
    state_r == ST_IDLE && !chanEnable |=> state_r == ST_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled channel started");
  property p_finish_busy;
    state_r == ST_BUSY && !xferAck |=> state_r == ST_BUSY && xferReq;
  endproperty
  a_finish_busy: assert property (p_finish_busy) else $error("accepted unit abandoned");
  property p_unit_size;
    go |=> xferByteUnit == $past(ctrl_r[BIT_SIZE]);
  endproperty
  a_unit_size: assert property (p_unit_size) else $error("unit size not latched");
  property p_done_drop;
    doneNow |=> !reqFlag_r && unitDone ##1 !unitDone;
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("flag kept after unit");

  c_ring_wrap: cover property (doneNow && ringWrap);
  c_normal_done: cover property (doneNow && !ringMode);
  c_drop: cover property (drop);
  c_disable_busy: cover property (state_r == ST_BUSY && !chanEnable ##1 doneNow);

endmodule
